// ---- hdl/disr_pkg.sv ----
/*
  Package for the discrete input serial reader: widths and sampler depths.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package disr_pkg;
  localparam int          CHANNELS     = 8;
  localparam int          SYNC_STAGES  = 3;
  localparam logic        LEVEL_GROUND = 1'h0;
  localparam logic        LEVEL_OPEN   = 1'h1;
  localparam logic [1:0]  RST_ASSERTED = 2'h0;
  localparam logic [1:0]  RST_RELEASED = 2'h3;
  localparam real         SCLK_MAX_MHZ = 10.0;
  localparam real         CLK_MHZ      = 100.0;
  localparam int          SCLK_MIN_CLKS = int'(CLK_MHZ / SCLK_MAX_MHZ);
endpackage : disr_pkg

// ---- hdl/disr_top.sv ----
/*
  Discrete input serial reader: parallel capture on chip select fall, serial shift on serial clock rise.
  Assumes the host pins (chip select, serial clock, serial in) and the channel levels are asynchronous
  to clk, and that an external wire resolves serial_out from its output enable.
*/
// Function
// R1 - The channel states are held in an eight-bit register loaded in parallel and read out serially.
// R2 - With chip select high the output is released and serial clock edges leave the register alone.
// R3 - Each falling chip select copies channel n into register bit n.
// R4 - With chip select low each rising serial clock moves bit n to bit n+1 and takes serial in into bit 1.
// R5 - The serial output shows register bit 8, updated after each rising serial clock.
// R6 - A low chip select enables both the output driver and shifting.
// R7 - A grounded channel is stored as 0 and an open channel as 1.
// R8 - Eight-cycle single reads and sixteen-cycle two-device chained reads both work.
// R9 - The host keeps the serial clock at or below ten megahertz.
// R10 - The host holds serial clock low at chip select fall and samples before each rising edge.
module disr_top #(
  parameter int WIDTH = disr_pkg::CHANNELS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             cs_n,
  input  wire logic             sclk,
  input  wire logic             serial_in,
  input  wire logic [WIDTH-1:0] din,
  output logic                  serial_out,
  output logic                  serial_out_oe
);
  initial begin
    if (WIDTH < 2) $error("WIDTH must be at least 2");
  end

  localparam int S = disr_pkg::SYNC_STAGES;

  logic [1:0]       rst_sync_q;
  logic             rst_ok_n;
  logic [S-1:0]     cs_sync_q;
  logic [S-1:0]     sclk_sync_q;
  logic [S-1:0]     si_sync_q;
  logic [WIDTH-1:0] din_s1_q;
  logic [WIDTH-1:0] din_s2_q;
  logic             cs_n_q;
  logic             sclk_q;
  logic             si_q;
  logic [WIDTH-1:0] capture_shift_register_q;
  logic [WIDTH-1:0] capture_shift_register_d;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= disr_pkg::RST_ASSERTED;
    else rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_ok_n = rst_sync_q[1];

  // Three-stage samplers on the host pins; a level change counts once the last two stages agree; channels pass two plain stages
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      cs_sync_q   <= '1;
      sclk_sync_q <= '0;
      si_sync_q   <= '0;
      din_s1_q    <= '0;
      din_s2_q    <= '0;
      cs_n_q      <= 1'h1;
      sclk_q      <= 1'h0;
      si_q        <= 1'h0;
    end else begin
      cs_sync_q   <= {cs_sync_q[S-2:0], cs_n};
      sclk_sync_q <= {sclk_sync_q[S-2:0], sclk};
      si_sync_q   <= {si_sync_q[S-2:0], serial_in};
      din_s1_q    <= din;
      din_s2_q    <= din_s1_q;
      if (cs_sync_q[S-1] == cs_sync_q[S-2]) cs_n_q <= cs_sync_q[S-1];
      if (sclk_sync_q[S-1] == sclk_sync_q[S-2]) sclk_q <= sclk_sync_q[S-1];
      if (si_sync_q[S-1] == si_sync_q[S-2]) si_q <= si_sync_q[S-1];
    end
  end

  wire cs_next   = (cs_sync_q[S-1] == cs_sync_q[S-2]) ? cs_sync_q[S-1] : cs_n_q;
  wire sclk_next = (sclk_sync_q[S-1] == sclk_sync_q[S-2]) ? sclk_sync_q[S-1] : sclk_q;
  wire si_next   = (si_sync_q[S-1] == si_sync_q[S-2]) ? si_sync_q[S-1] : si_q;
  wire cs_fall   = cs_n_q && !cs_next;                                 // [R3]
  wire sclk_rise = !sclk_q && sclk_next && !cs_n_q && !cs_next;        // [R2] [R6]

  // Channel levels pass through unchanged: ground reads 0, open reads 1 [R7]
  always_comb begin
    capture_shift_register_d = capture_shift_register_q;
    if (cs_fall) capture_shift_register_d = din_s2_q;                  // [R1] [R3]
    else if (sclk_rise) begin
      capture_shift_register_d = {capture_shift_register_q[WIDTH-2:0], si_next}; // [R4] [R8]
    end
  end

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      capture_shift_register_q <= '0;
      serial_out               <= disr_pkg::LEVEL_GROUND;
      serial_out_oe            <= 1'h0;
    end else begin
      capture_shift_register_q <= capture_shift_register_d;
      serial_out               <= capture_shift_register_d[WIDTH-1];  // [R5]
      serial_out_oe            <= !cs_next;                            // [R2] [R6]
    end
  end

  AST_HIZ_WHEN_DESELECTED: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (cs_n_q && cs_next) |=> !serial_out_oe) else $error("output driven while deselected"); // [R2]
  AST_HOLD_WHEN_DESELECTED: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (cs_n_q && cs_next) |=> $stable(capture_shift_register_q)) else $error("register moved while deselected"); // [R2]
  AST_LOAD_ON_SELECT: assert property (@(posedge clk) disable iff (!rst_ok_n)
    cs_fall |=> capture_shift_register_q == $past(din_s2_q)) else $error("parallel load wrong"); // [R3]
  AST_SHIFT_ON_RISE: assert property (@(posedge clk) disable iff (!rst_ok_n)
    sclk_rise |=> capture_shift_register_q[0] == $past(si_next)
      && capture_shift_register_q[WIDTH-1:1] == $past(capture_shift_register_q[WIDTH-2:0]))
    else $error("shift wrong"); // [R4]
  AST_OUT_IS_MSB: assert property (@(posedge clk) disable iff (!rst_ok_n)
    serial_out == capture_shift_register_q[WIDTH-1]) else $error("serial out not msb"); // [R5]
  AST_OE_FOLLOWS_SELECT: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (!cs_n_q && !cs_next) |=> serial_out_oe) else $error("driver off while selected"); // [R6]
  AST_OPEN_READS_ONE: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (cs_fall && din_s2_q[WIDTH-1] == disr_pkg::LEVEL_OPEN) |=> serial_out == disr_pkg::LEVEL_OPEN)
    else $error("open channel not 1"); // [R7]
  AST_QUIET_NO_SHIFT: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (!cs_fall && !sclk_rise) |=> $stable(capture_shift_register_q)) else $error("spurious change"); // [R1]
  AST_LOAD_IS_MSB_OUT: assert property (@(posedge clk) disable iff (!rst_ok_n)
    cs_fall |=> serial_out == $past(din_s2_q[WIDTH-1])) else $error("first bit not top channel"); // [R8]

  COV_LOAD: cover property (@(posedge clk) disable iff (!rst_ok_n) cs_fall);
  COV_SHIFT: cover property (@(posedge clk) disable iff (!rst_ok_n) sclk_rise);
  COV_DESELECT: cover property (@(posedge clk) disable iff (!rst_ok_n) !cs_n_q ##1 cs_n_q);

  // Shift bookkeeping for the read covers below: rising serial clocks counted since the last load
  localparam int CW = $clog2(2 * WIDTH + 1) + 1;

  logic [CW-1:0] shift_count_q;
  wire           count_full  = &shift_count_q;
  wire           single_done = (shift_count_q == CW'(WIDTH));
  wire           chain_done  = (shift_count_q == CW'(2 * WIDTH));
  wire           cs_rise     = !cs_n_q && cs_next;

  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      shift_count_q <= '0;
    end else if (cs_fall) begin
      shift_count_q <= '0;
    end else if (sclk_rise && !count_full) begin
      shift_count_q <= shift_count_q + CW'(1);
    end
  end

  // Driver enable tracks the filtered select level
  AST_OE_ON_SELECT: assert property (@(posedge clk) disable iff (!rst_ok_n)
    cs_fall |=> serial_out_oe)
    else $error("driver not enabled on select"); // [R6]
  AST_OE_RELEASE: assert property (@(posedge clk) disable iff (!rst_ok_n)
    cs_rise |=> !serial_out_oe)
    else $error("driver not released on deselect"); // [R2]

  // No serial clock rise is taken during a load or while deselected
  AST_NO_SHIFT_ON_LOAD: assert property (@(posedge clk) disable iff (!rst_ok_n)
    cs_fall |-> !sclk_rise)
    else $error("shift during load"); // [R3]
  AST_DESELECT_NO_RISE: assert property (@(posedge clk) disable iff (!rst_ok_n)
    cs_n_q |-> !sclk_rise)
    else $error("shift while deselected"); // [R2]

  // Samplers only move once the two last stages agree
  AST_CS_FILTERED: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (cs_sync_q[S-1] != cs_sync_q[S-2]) |=> $stable(cs_n_q))
    else $error("select moved on disagreeing stages"); // [R2]
  AST_SCLK_FILTERED: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (sclk_sync_q[S-1] != sclk_sync_q[S-2]) |=> $stable(sclk_q))
    else $error("serial clock moved on disagreeing stages"); // [R4]

  // Each rise presents the next lower bit on the output
  AST_NEXT_BIT_OUT: assert property (@(posedge clk) disable iff (!rst_ok_n)
    sclk_rise |=> serial_out == $past(capture_shift_register_q[WIDTH-2]))
    else $error("next bit not presented"); // [R5]
  AST_OUT_HOLDS: assert property (@(posedge clk) disable iff (!rst_ok_n)
    (!cs_fall && !sclk_rise) |=> $stable(serial_out))
    else $error("output moved without an edge"); // [R5]

  COV_SINGLE_READ: cover property (@(posedge clk) disable iff (!rst_ok_n) single_done && cs_rise); // [R8]
  COV_CHAIN_READ: cover property (@(posedge clk) disable iff (!rst_ok_n) chain_done && cs_rise); // [R8]
endmodule : disr_top

// ---- tb/disr_host.sv ----
/* SPI host model for the serial reader.
   Assumes the reader samples these pins with its own faster clock. */
module disr_host (
  output logic      cs_n,
  output logic      sclk,
  output logic      serial_in,
  input  wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cs_n = 1'h1;
  initial sclk = 1'h0;
  initial serial_in = 1'h0;
  task automatic xfer(input int n, input logic [15:0] up, output logic [15:0] got);
    got = 16'h0;
    serial_in = up[15];
    cs_n = 1'h0;
    #100ns;
    for (int k = 0; k < n; k++) begin
      got = {got[14:0], serial_out};
      sclk = 1'h1;
      #62.5ns;
      sclk = 1'h0;
      if (k < 15) serial_in = up[14-k];
      #62.5ns;
    end
    cs_n = 1'h1;
    serial_in = ~serial_in;
    #100ns;
  endtask : xfer
endmodule : disr_host

// ---- tb/tb_top.sv ----
/* Bench for the serial reader driven by the host model.
   Assumes the design's sampling latencies of a few clk. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, cs_n, sclk, serial_in, serial_out, serial_out_oe;
  logic [7:0] din;
  int         fail_count = 0;
  int         n_checks = 0;
  int         cycles = 0;
  disr_top u_disr_top (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
                       .din(din), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  disr_host u_disr_host (.cs_n(cs_n), .sclk(sclk), .serial_in(serial_in), .serial_out(serial_out));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic single_read(input logic [7:0] v);
    logic [15:0] got;
    @(negedge clk) din = v;
    repeat (4) @(negedge clk);
    fork
      u_disr_host.xfer(8, 16'h0, got);
      #80ns check({15'h0, serial_out_oe}, 16'h1);
    join
    check(got, {8'h0, v});
    check({15'h0, serial_out_oe}, 16'h0);
  endtask : single_read
  task automatic chain_read();
    logic [15:0] got;
    @(negedge clk) din = 8'h3c;
    repeat (4) @(negedge clk);
    u_disr_host.xfer(16, 16'h9600, got);
    check(got, 16'h3c96);
  endtask : chain_read
  task automatic idle_clocks();
    @(negedge clk);
    repeat (4) begin
      u_disr_host.sclk = 1'h1;
      repeat (6) @(negedge clk);
      check({15'h0, serial_out_oe}, 16'h0);
      u_disr_host.sclk = 1'h0;
      repeat (6) @(negedge clk);
    end
  endtask : idle_clocks
  initial begin
    clk = 1'h0;
    forever #5ns clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    rst_n = 1'h0;
    din = 8'h0;
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    repeat (8) @(negedge clk);
    single_read(8'ha5);
    single_read(8'h00);
    single_read(8'hff);
    single_read(8'h81);
    idle_clocks();
    single_read(8'h5a);
    chain_read();
    conclude();
  end
endmodule : tb_top
